//--- rtl/rot_params.svh
// Behaviour
// - Hold 17-bit start offset over three registers; rotated mode reads it as bytes.
// - Rotated mode uses line byte count as byte distance between line starts; code adds it between fetches in a line, and line starts step one byte back.
// - Line byte count is ignored entirely in landscape mode.
// - Enable bit 0 means landscape, other mode fields ignored; 1 means rotated.
// - Scheme select 0 picks default scheme, 1 picks alternate scheme.
// - Boost bit 2 runs memory clock at source rate during CPU accesses only.
// - Rotated mode takes the input clock pin as the rotation source clock.
// - No split-screen operation while rotated mode is enabled.
// - Default scheme pixel clock may equal the source clock.
// - Alternate scheme pixel clock is half the source clock.
// - Vertical panning steps two lines in default, one line in alternate.
// - Two pixel clock select bits divide the pixel clock further down.
`ifndef ROT_PARAMS_SVH
`define ROT_PARAMS_SVH

// Register indices, byte address is four times the index
`define IDX_START_LOW   8'h0c
`define IDX_START_MID   8'h0d
`define IDX_START_HIGH  8'h0e
`define IDX_ROT_MODE    8'h1b
`define IDX_LINE_STRIDE 8'h1c
`define IDX_STATUS      8'h1d

// Rotation mode register fields
`define ROT_EN_BIT      7
`define ROT_ALT_BIT     6
`define ROT_BOOST_BIT   2
`define ROT_PSEL_HI     1
`define ROT_PSEL_LO     0
`define ROT_MODE_MASK   8'hc7

// Status register fields
`define STAT_ROT_BIT    0
`define STAT_ALT_BIT    1
`define STAT_FULL_BIT   2
`define STAT_PEND_BIT   3

// Reset values
`define RST_BYTE        8'h00
`define RST_HIGH_BIT    1'b0

// Address width and clocking
`define ADDR_W          17
`define MCLK_PERIOD_NS  25
`define ALT_BASE_DIV    4'h2
`define DEF_BASE_DIV    4'h1

`endif

//--- rtl/rot_pkg.sv
package rot_pkg;

  // Refresh scan states
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_SCAN = 3'b010,
    S_HOLD = 3'b100
  } scan_state_t;

endpackage : rot_pkg

//--- rtl/pixel_clock_divider.sv
`timescale 1ns/1ps
`include "rot_params.svh"

module pixel_clock_divider (
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic       i_ce,
  // Mode
  input  wire logic       i_rot_en,
  input  wire logic       i_alt,
  input  wire logic [1:0] i_pclk_sel,
  // Pixel pulse
  output logic            o_pix_tick
);

  logic [4:0] cnt_ff;
  logic [4:0] div;
  logic       div8_mode;

  // Base ratio shifted by pixel clock select, widest ratio is sixteen
  always_comb begin
    div = i_alt ? 5'(`ALT_BASE_DIV) : 5'(`DEF_BASE_DIV);
    div = div << i_pclk_sel;
    if (!i_rot_en) begin
      div = 5'(`DEF_BASE_DIV);
    end
  end

  // Default scheme with the slowest select, for the spacing check
  assign div8_mode = i_rot_en && !i_alt && i_pclk_sel == 2'h3;

  // Cycle counter
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff <= 5'h00;
    end else if (i_ce) begin
      cnt_ff <= (cnt_ff >= div - 5'h01) ? 5'h00 : cnt_ff + 5'h01;
    end
  end

  assign o_pix_tick = i_ce && (cnt_ff >= div - 5'h01);

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst || !i_ce);

  property p_half_rate;
    i_rot_en && i_alt && i_pclk_sel == 2'h0 && o_pix_tick ##1 $stable(i_alt) |-> !o_pix_tick;
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("alternate pixel tick too fast");

  property p_full_rate;
    i_rot_en && !i_alt && i_pclk_sel == 2'h0 && $stable(i_pclk_sel) && $stable(i_alt) |-> o_pix_tick;
  endproperty
  a_full_rate: assert property (p_full_rate) else $error("default pixel tick missing");

  property p_div8;
    div8_mode && o_pix_tick && $stable(i_pclk_sel)
      |=> (!o_pix_tick || !div8_mode) [*7] ##1 (o_pix_tick || !div8_mode);
  endproperty
  a_div8: assert property (p_div8) else $error("divide by eight spacing wrong");

endmodule : pixel_clock_divider

//--- rtl/fetch_skid_buffer.sv
`timescale 1ns/1ps

module fetch_skid_buffer #(
  parameter int W     = 17,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  // Filling side
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_data,
  output logic              o_ready,
  // Draining side
  output logic              o_valid,
  output logic [W-1:0]      o_data,
  input  wire logic         i_ready
);

  localparam int PW = $clog2(DEPTH);

  logic [W-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ff;
  logic [PW-1:0] rd_ff;
  logic [PW:0]   cnt_ff;
  logic          push;
  logic          pop;

  assign o_ready = (cnt_ff != (PW+1)'(DEPTH));
  assign o_valid = (cnt_ff != '0);
  assign push    = i_ce && i_valid && o_ready;
  assign pop     = i_ce && o_valid && i_ready;
  assign o_data  = mem_ff[rd_ff];

  // Storage
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_ff[wr_ff] <= i_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == PW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == PW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule : fetch_skid_buffer

//--- rtl/rotated_display_address_control.sv
`timescale 1ns/1ps
`include "rot_params.svh"

module rotated_display_address_control (
  // Clock, reset, enable
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst,
  input  wire logic                 i_ce,
  // APB slave
  input  wire logic                 i_psel,
  input  wire logic                 i_penable,
  input  wire logic                 i_pwrite,
  input  wire logic [9:0]           i_paddr,
  input  wire logic [31:0]          i_pwdata,
  output logic      [31:0]          o_prdata,
  output logic                      o_pready,
  output logic                      o_pslverr,
  // Panel timing, same clock
  input  wire logic                 i_frame_start,
  input  wire logic                 i_line_start,
  input  wire logic                 i_line_active,
  // CPU memory access in progress
  input  wire logic                 i_cpu_access,
  // Refresh fetch stream
  output logic                      o_fetch_valid,
  output logic [`ADDR_W-1:0]        o_fetch_addr,
  input  wire logic                 i_fetch_ready,
  // Clock steering
  output logic                      o_src_from_input_pin,
  output logic                      o_mclk_full_rate,
  output logic                      o_pix_tick,
  // Split screen gating
  input  wire logic                 i_split_req,
  output logic                      o_split_en,
  // Mode status
  output logic                      o_rotated
);

  // Register state
  logic [7:0]          start_low_ff;
  logic [7:0]          start_mid_ff;
  logic                start_high_ff;
  logic [7:0]          mode_ff;
  logic [7:0]          stride_ff;
  logic [31:0]         prdata_ff;
  logic                pslverr_ff;

  // Scan state
  rot_pkg::scan_state_t state_ff;
  rot_pkg::scan_state_t nxt_state;
  logic [`ADDR_W-1:0]  addr_ff;
  logic [`ADDR_W-1:0]  nxt_addr;
  logic [`ADDR_W-1:0]  row_base_ff;
  logic [`ADDR_W-1:0]  nxt_row_base;

  // Decoded fields
  logic                rot_en;
  logic                alt;
  logic                boost;
  logic [1:0]          pclk_sel;
  logic [`ADDR_W-1:0]  start_offs;
  logic [`ADDR_W-1:0]  eff_start;
  logic                pix_tick;
  logic                buf_ready;
  logic                push;
  logic                setup;
  logic                wr_en;
  logic [7:0]          acc_idx;

  // Register index of a byte address
  function automatic logic [7:0] reg_index(input logic [9:0] addr);
    reg_index = addr[9:2];
  endfunction : reg_index

  // Whether an index maps to a register
  function automatic logic reg_mapped(input logic [7:0] idx, input logic aligned);
    reg_mapped = aligned && (idx == `IDX_START_LOW || idx == `IDX_START_MID ||
                 idx == `IDX_START_HIGH || idx == `IDX_ROT_MODE ||
                 idx == `IDX_LINE_STRIDE || idx == `IDX_STATUS);
  endfunction : reg_mapped

  assign acc_idx = reg_index(i_paddr);
  assign setup   = i_psel && !i_penable;
  assign wr_en   = i_ce && i_psel && i_penable && i_pwrite && o_pready &&
                   reg_mapped(acc_idx, i_paddr[1:0] == 2'h0);

  // mode fields only count when enabled
  assign rot_en   = mode_ff[`ROT_EN_BIT];
  assign alt      = rot_en && mode_ff[`ROT_ALT_BIT];
  assign boost    = rot_en && mode_ff[`ROT_BOOST_BIT];
  assign pclk_sel = rot_en ? mode_ff[`ROT_PSEL_HI:`ROT_PSEL_LO] : 2'h0;

  assign start_offs = {start_high_ff, start_mid_ff, start_low_ff};

  // Start address of a frame
  always_comb begin
    if (!rot_en) begin
      // Landscape uses a word offset
      eff_start = {start_offs[15:0], 1'b0};
    end else if (alt) begin
      eff_start = start_offs;
    end else begin
      eff_start = {start_offs[16:1], 1'b1};
    end
  end

  // Start offset registers
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      start_low_ff  <= `RST_BYTE;
      start_mid_ff  <= `RST_BYTE;
      start_high_ff <= `RST_HIGH_BIT;
    end else if (wr_en) begin
      if (acc_idx == `IDX_START_LOW) begin
        start_low_ff <= i_pwdata[7:0];
      end
      if (acc_idx == `IDX_START_MID) begin
        start_mid_ff <= i_pwdata[7:0];
      end
      if (acc_idx == `IDX_START_HIGH) begin
        start_high_ff <= i_pwdata[0];
      end
    end
  end

  // Mode and stride registers
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      mode_ff   <= `RST_BYTE;
      stride_ff <= `RST_BYTE;
    end else if (wr_en) begin
      if (acc_idx == `IDX_ROT_MODE) begin
        mode_ff <= i_pwdata[7:0] & `ROT_MODE_MASK;
      end
      if (acc_idx == `IDX_LINE_STRIDE) begin
        stride_ff <= i_pwdata[7:0];
      end
    end
  end

  // Read data and error captured in setup phase
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (i_ce && setup) begin
      pslverr_ff <= !reg_mapped(acc_idx, i_paddr[1:0] == 2'h0);
      case (acc_idx)
        `IDX_START_LOW:   prdata_ff <= {24'h000000, start_low_ff};
        `IDX_START_MID:   prdata_ff <= {24'h000000, start_mid_ff};
        `IDX_START_HIGH:  prdata_ff <= {31'h00000000, start_high_ff};
        `IDX_ROT_MODE:    prdata_ff <= {24'h000000, mode_ff};
        `IDX_LINE_STRIDE: prdata_ff <= {24'h000000, stride_ff};
        `IDX_STATUS: begin
          prdata_ff                  <= 32'h0000_0000;
          prdata_ff[`STAT_ROT_BIT]   <= rot_en;
          prdata_ff[`STAT_ALT_BIT]   <= alt;
          prdata_ff[`STAT_FULL_BIT]  <= o_mclk_full_rate;
          prdata_ff[`STAT_PEND_BIT]  <= o_fetch_valid;
        end
        default:          prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Access phase always completes in one cycle
  assign o_pready  = i_psel && i_penable;
  assign o_prdata  = prdata_ff;
  assign o_pslverr = o_pready && pslverr_ff;

  // rotation section clocked from input pin
  assign o_src_from_input_pin = rot_en;
  // boost only while CPU accesses memory
  assign o_mclk_full_rate = boost && i_cpu_access;
  // split screen blocked in rotated mode
  assign o_split_en = i_split_req && !rot_en;
  assign o_rotated  = rot_en;
  assign o_pix_tick = pix_tick;

  // Pixel clock ratio
  pixel_clock_divider u_pix_div (
    .i_mclk     (i_mclk),
    .i_rst      (i_rst),
    .i_ce       (i_ce),
    .i_rot_en   (rot_en),
    .i_alt      (alt),
    .i_pclk_sel (pclk_sel),
    .o_pix_tick (pix_tick)
  );

  // Fetch pushes on a pixel tick with room
  assign push = (state_ff == rot_pkg::S_SCAN) && i_line_active && pix_tick && buf_ready &&
                !i_frame_start && !i_line_start;

  // Scan state and address steps
  always_comb begin
    nxt_state    = state_ff;
    nxt_addr     = addr_ff;
    nxt_row_base = row_base_ff;
    case (state_ff)
      rot_pkg::S_IDLE: begin
        if (i_frame_start) begin
          nxt_state = rot_pkg::S_SCAN;
        end
      end
      rot_pkg::S_SCAN: begin
        if (!i_line_active) begin
          nxt_state = rot_pkg::S_HOLD;
        end
      end
      rot_pkg::S_HOLD: begin
        if (i_line_start || i_frame_start) begin
          nxt_state = rot_pkg::S_SCAN;
        end
      end
      default: begin
        nxt_state = rot_pkg::S_IDLE;
      end
    endcase
    if (i_frame_start) begin
      nxt_addr     = eff_start;
      nxt_row_base = eff_start;
    end else if (i_line_start && rot_en) begin
      // Next panel row is one byte back
      nxt_row_base = row_base_ff - `ADDR_W'(1);
      nxt_addr     = row_base_ff - `ADDR_W'(1);
    end else if (push) begin
      nxt_addr = rot_en ? addr_ff + `ADDR_W'(stride_ff) : addr_ff + `ADDR_W'(1);
    end
  end

  // Scan registers
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_ff    <= rot_pkg::S_IDLE;
      addr_ff     <= '0;
      row_base_ff <= '0;
    end else if (i_ce) begin
      state_ff    <= nxt_state;
      addr_ff     <= nxt_addr;
      row_base_ff <= nxt_row_base;
    end
  end

  // Buffer in the fetch path
  fetch_skid_buffer #(
    .W     (`ADDR_W),
    .DEPTH (2)
  ) u_fetch_buf (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_ce    (i_ce),
    .i_valid (push),
    .i_data  (addr_ff),
    .o_ready (buf_ready),
    .o_valid (o_fetch_valid),
    .o_data  (o_fetch_addr),
    .i_ready (i_fetch_ready)
  );

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst || !i_ce);

  property p_start_bytes;
    i_frame_start && rot_en && alt |=> addr_ff == $past(start_offs);
  endproperty
  a_start_bytes: assert property (p_start_bytes) else $error("rotated start not byte offset");

  property p_stride_step;
    push && rot_en && $stable(stride_ff) |=> addr_ff == $past(addr_ff) + `ADDR_W'(stride_ff);
  endproperty
  a_stride_step: assert property (p_stride_step) else $error("rotated step not stride");

  property p_landscape_step;
    push && !rot_en |=> addr_ff == $past(addr_ff) + `ADDR_W'(1);
  endproperty
  a_landscape_step: assert property (p_landscape_step) else $error("landscape used stride");

  property p_mode_ignored;
    !rot_en |-> !alt && !o_mclk_full_rate && pclk_sel == 2'h0;
  endproperty
  a_mode_ignored: assert property (p_mode_ignored) else $error("fields active in landscape");

  property p_scheme;
    rot_en |-> alt == mode_ff[`ROT_ALT_BIT];
  endproperty
  a_scheme: assert property (p_scheme) else $error("scheme select mismatch");

  property p_boost;
    o_mclk_full_rate |-> i_cpu_access && mode_ff[`ROT_BOOST_BIT] && rot_en;
  endproperty
  a_boost: assert property (p_boost) else $error("boost outside cpu access");

  property p_src_pin;
    o_src_from_input_pin == rot_en;
  endproperty
  a_src_pin: assert property (p_src_pin) else $error("source clock routing wrong");

  property p_no_split;
    rot_en |-> !o_split_en;
  endproperty
  a_no_split: assert property (p_no_split) else $error("split screen in rotated mode");

  property p_pan_two;
    i_frame_start && rot_en && !alt |=> addr_ff[0] && addr_ff[16:1] == $past(start_offs[16:1]);
  endproperty
  a_pan_two: assert property (p_pan_two) else $error("default start not paired");

  property p_row_start;
    i_frame_start ##1 (push && rot_en) |-> o_fetch_valid || buf_ready;
  endproperty
  a_row_start: assert property (p_row_start) else $error("fetch lost at row start");

  // Landscape frame starts at the doubled word offset
  property p_landscape_start;
    i_frame_start && !rot_en |=> addr_ff == {$past(start_offs[15:0]), 1'b0};
  endproperty
  a_landscape_start: assert property (p_landscape_start) else $error("landscape start not word offset");

  // Each new rotated row begins one byte back
  property p_row_back;
    i_line_start && !i_frame_start && rot_en |=> row_base_ff == $past(row_base_ff) - `ADDR_W'(1);
  endproperty
  a_row_back: assert property (p_row_back) else $error("rotated row base not stepped back");

  // A stalled fetch word stays put
  property p_stall_hold;
    o_fetch_valid && !i_fetch_ready |=> o_fetch_valid && $stable(o_fetch_addr);
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("fetch word lost during stall");

endmodule : rotated_display_address_control

//--- test/panel_fetch_sink.sv
`timescale 1ns/1ps

module panel_fetch_sink (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst,
  // Fetch stream
  input  wire logic i_valid,
  output logic      o_ready,
  // Bench control
  input  wire logic i_hold,
  output logic      o_take
);
  logic [7:0] lfsr_ff;

  // model holds no pixel memory, clearing it is software's job

  // Stall pattern, prompt and slow acceptance mixed
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      lfsr_ff <= 8'h5b;
    end else begin
      lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
    end
  end

  // Ready never raised while held
  assign o_ready = !i_hold && lfsr_ff[0];
  assign o_take  = i_valid && o_ready;
endmodule : panel_fetch_sink

//--- test/rotated_display_address_control_bench.sv
`timescale 1ns/1ps
`include "rot_params.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, a, b); end end

module rotated_display_address_control_bench;
  logic        mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [9:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, seed = 89;
  logic        pready, pslverr, er, fetch_valid, fetch_ready, take;
  logic        frame_start = 0, line_start = 0, line_active = 0, cpu_access = 0;
  logic        split_req = 0, hold = 0, src_pin, full_rate, pix_tick, split_en, rotated;
  logic [16:0] fetch_addr, exp_addr = 0, row_base, step = 1;
  logic [7:0]  v, idx_tab [5], mask_tab [5];
  int          n_errors = 0, n_tests = 0, cycles = 0, n_pop = 0, cnt;

  rotated_display_address_control dut_u (
    .i_mclk(mclk), .i_rst(rst), .i_ce(1'b1), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_frame_start(frame_start),
    .i_line_start(line_start), .i_line_active(line_active), .i_cpu_access(cpu_access),
    .o_fetch_valid(fetch_valid), .o_fetch_addr(fetch_addr), .i_fetch_ready(fetch_ready),
    .o_src_from_input_pin(src_pin), .o_mclk_full_rate(full_rate), .o_pix_tick(pix_tick),
    .i_split_req(split_req), .o_split_en(split_en), .o_rotated(rotated));

  panel_fetch_sink sink_u (
    .i_mclk(mclk), .i_rst(rst), .i_valid(fetch_valid), .o_ready(fetch_ready),
    .i_hold(hold), .o_take(take));

  // Clock, 25 ns period
  initial begin
    forever #12.5 mclk = ~mclk;
  end

  // Xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Expected first fetch address
  function automatic logic [16:0] start_expect(logic [7:0] m, logic [16:0] off);
    if (!m[7]) return {off[15:0], 1'b0};
    if (m[6]) return off;
    return {off[16:1], 1'b1};
  endfunction : start_expect

  task automatic give_verdict();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  // One APB transfer, waits for pready
  task automatic apb(input logic wr, input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    // Ends on pready; only the bench timeout ends a wait that never sees it
    do begin @(posedge mclk); end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // Popped addresses follow the fetch sequence
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 6000) begin n_errors++; give_verdict(); end
    if (take === 1'b1) begin
      `CHK(fetch_addr, exp_addr)
      exp_addr = exp_addr + step;
      n_pop++;
    end
  end

  task automatic run_fetch(input logic [7:0] m, input logic [16:0] off, input logic [7:0] s);
    apb(1, {`IDX_START_LOW, 2'b00}, off[7:0]);
    apb(1, {`IDX_START_MID, 2'b00}, off[15:8]);
    apb(1, {`IDX_START_HIGH, 2'b00}, {7'h0, off[16]});
    apb(1, {`IDX_LINE_STRIDE, 2'b00}, s);
    apb(1, {`IDX_ROT_MODE, 2'b00}, m);
    row_base = start_expect(m, off);
    exp_addr = row_base;
    step = m[7] ? {9'h0, s} : 17'h1;
    n_pop = 0;
    @(posedge mclk); hold <= 1; frame_start <= 1;
    @(posedge mclk); frame_start <= 0; line_active <= 1;
    repeat (12) @(posedge mclk);
    `CHK(fetch_valid, 1'b1)
    hold <= 0;
    repeat (40) @(posedge mclk);
    line_active <= 0;
    repeat (30) @(posedge mclk);
    if (m[7]) begin
      row_base = row_base - 17'h1;
      exp_addr = row_base;
      line_start <= 1;
      @(posedge mclk); line_start <= 0; line_active <= 1;
      repeat (30) @(posedge mclk);
      line_active <= 0;
      repeat (30) @(posedge mclk);
    end
    `CHK(fetch_valid, 1'b0)
    `CHK(n_pop > 8, 1'b1)
  endtask : run_fetch

  initial begin
    idx_tab = '{`IDX_START_LOW, `IDX_START_MID, `IDX_START_HIGH, `IDX_ROT_MODE, `IDX_LINE_STRIDE};
    mask_tab = '{8'hff, 8'hff, 8'h01, `ROT_MODE_MASK, 8'hff};
    repeat (16) @(posedge mclk);
    rst <= 0;
    `CHK(fetch_valid, 1'b0)
    // Reset values, then random write and readback
    for (int i = 0; i < 5; i++) begin
      apb(0, {idx_tab[i], 2'b00}, 8'h00);
      `CHK(rd, 32'h0)
      v = 8'(rnd());
      apb(1, {idx_tab[i], 2'b00}, v);
      apb(0, {idx_tab[i], 2'b00}, 8'h00);
      `CHK({rd, er}, {24'h0, v & mask_tab[i], 1'b0})
    end
    // Unmapped and misaligned places refused
    apb(1, 10'h080, 8'h5a);
    `CHK(er, 1'b1)
    apb(0, 10'h080, 8'h00);
    `CHK({rd, er}, {32'h0, 1'b1})
    apb(0, 10'h031, 8'h00);
    `CHK(er, 1'b1)
    // Mode bits steer clock, split and status
    for (int i = 0; i < 10; i++) begin
      v = 8'(rnd());
      apb(1, {`IDX_ROT_MODE, 2'b00}, v);
      // boost requests, memory clock limit left to software
      cpu_access <= v[3];
      split_req <= v[4];
      @(posedge mclk);
      @(negedge mclk);
      `CHK({rotated, src_pin}, {2{v[7]}})
      `CHK(full_rate, v[7] & v[2] & v[3])
      `CHK(split_en, v[4] & !v[7])
      apb(0, {`IDX_STATUS, 2'b00}, 8'h00);
      `CHK(rd[1:0], {v[7] & v[6], v[7]})
      `CHK(rd[3:2], {1'b0, v[7] & v[2] & v[3]})
    end
    cpu_access <= 0;
    // Pixel tick rates for every scheme and select
    for (int m = 0; m < 9; m++) begin
      v = (m == 8) ? 8'h47 : {1'b1, m[2], 4'h0, m[1:0]};
      apb(1, {`IDX_ROT_MODE, 2'b00}, v);
      repeat (4) @(posedge mclk);
      cnt = 0;
      repeat (64) begin @(posedge mclk); cnt += (pix_tick === 1'b1); end
      `CHK(cnt, (m == 8) ? 64 : (64 >> ((m >> 2) + (m & 3))))
    end
    run_fetch(8'h80, 17'h0007f, 8'h80);
    // input clock divider sits outside this block
    run_fetch(8'hc0, 17'h00077, 8'h78);
    run_fetch(8'h00, {1'b1, 16'(rnd())}, 8'h3c);
    give_verdict();
  end
endmodule : rotated_display_address_control_bench
